// ### mvoc_pkg.sv
// Constants and types shared by the measured value output conditioner.
package mvoc_pkg;
  localparam int unsigned DECIM_MAX = 3000000;
  localparam int unsigned DECIM_W = 22;
  localparam int unsigned HOLD_MAX = 1024;
  localparam int unsigned HOLD_W = 11;
  localparam int unsigned FPP_MAX = 350;
  localparam int unsigned FPP_W = 9;
  localparam logic [8:0] FPP_AUTO_COUNT = 9'h0_040;
  localparam int unsigned SIG_CNT = 8;
  localparam int unsigned VAL_W = 32;
  // Limit values are micrometre integers; 2147.0 mm is 2147000 um.
  localparam logic signed [31:0] LIMIT_MAX_UM = 32'sh0020_C2B8;
  localparam int unsigned PORT_MIN = 1024;
  localparam logic [15:0] PORT_RESET = 16'h0400;
  localparam int unsigned LOCK_MIN_MAX = 60;
  localparam longint unsigned CLK_HZ = 100000000;
  localparam longint unsigned MINUTE_S = 60;
  localparam longint unsigned MINUTE_CYCLES = CLK_HZ * MINUTE_S;
  typedef enum logic [1:0] {HOLD_NONE, HOLD_INFINITE, HOLD_COUNT} hold_mode_e;
  typedef enum logic [1:0] {
    SRC_INTENSITY, SRC_RANGE, SRC_EITHER, SRC_LIMIT
  } err_source_e;
  typedef enum logic [1:0] {DIR_LOWER, DIR_UPPER, DIR_BOTH} limit_dir_e;
  typedef enum logic [1:0] {
    DRIVE_HIGH_SIDE, DRIVE_LOW_SIDE, DRIVE_PUSH_PULL, DRIVE_INV_PUSH_PULL
  } drive_style_e;
  typedef enum logic {SCALE_STANDARD, SCALE_TWO_POINT} scale_style_e;
  typedef enum logic [1:0] {LOCK_NONE, LOCK_ACTIVE, LOCK_AUTO} lock_mode_e;
  typedef enum logic [1:0] {
    XPORT_NONE, XPORT_SERVER_TCP, XPORT_CLIENT_TCP, XPORT_CLIENT_UDP
  } transport_e;
  localparam int unsigned TGT_SERIAL = 0;
  localparam int unsigned TGT_ANALOG = 1;
  localparam int unsigned TGT_NETWORK = 2;
endpackage

// ### skid_buffer.sv
// Two-entry valid/ready buffer that loses no word when the sink stalls.
`timescale 1ns/1ps
`default_nettype none
module skid_buffer #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic [WIDTH-1:0] mem_d [2];
  logic rd_q, rd_d, wr_q, wr_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  always_comb
  begin
    in_ready = (cnt_q != 2'h2);
    out_valid = (cnt_q != 2'h0);
    out_data = mem_q[rd_q];
    push = in_valid && in_ready && clk_en;
    pop = out_valid && out_ready && clk_en;
    mem_d = mem_q;
    if (push)
    begin
      mem_d[wr_q] = in_data;
    end
    wr_d = push ? ~wr_q : wr_q;
    rd_d = pop ? ~rd_q : rd_q;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      mem_q <= mem_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // skid_buffer
`default_nettype wire

// ### measured_value_output_conditioner.sv
// Output conditioning of measured values: hold, decimation, packing, switch output.
`timescale 1ns/1ps
`default_nettype none
module measured_value_output_conditioner
  import mvoc_pkg::*;
#(
  parameter int unsigned NSIG = SIG_CNT,
  parameter longint unsigned LOCK_UNIT_CYCLES = MINUTE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic meas_valid,
  input wire logic [NSIG*VAL_W-1:0] meas_values,
  input wire logic meas_intensity_err,
  input wire logic meas_range_err,
  input wire logic [VAL_W-1:0] error_value,
  input wire logic [$clog2(NSIG)-1:0] limit_source_signal,
  input wire logic thickness_mode,
  input wire logic [DECIM_W-1:0] output_decimation_count,
  input wire logic [2:0] decimation_targets,
  input wire hold_mode_e error_hold_mode,
  input wire logic [HOLD_W-1:0] error_hold_count,
  input wire logic [FPP_W-1:0] frames_per_packet,
  input wire logic [NSIG-1:0] network_signal_selection,
  input wire logic [NSIG-1:0] serial_signal_selection,
  input wire err_source_e error_output_source,
  input wire limit_dir_e limit_direction,
  input wire logic signed [31:0] limit_lower,
  input wire logic signed [31:0] limit_upper,
  input wire logic signed [31:0] switch_hysteresis,
  input wire logic signed [31:0] measuring_span,
  input wire drive_style_e switch_drive_style,
  input wire scale_style_e analog_scaling_style,
  input wire logic signed [31:0] scale_bound_1,
  input wire logic signed [31:0] scale_bound_2,
  input wire lock_mode_e button_lock,
  input wire logic [5:0] lock_minutes,
  input wire transport_e value_transport,
  input wire logic [15:0] transport_port,
  input wire logic tcp_liveness_probe,
  input wire logic conn_open,
  output logic net_valid,
  input wire logic net_ready,
  output logic [VAL_W-1:0] net_data,
  output logic net_last,
  output logic ser_valid,
  input wire logic ser_ready,
  output logic [VAL_W-1:0] ser_data,
  output logic analog_valid,
  output logic signed [31:0] analog_value,
  output logic signed [31:0] analog_lo,
  output logic signed [31:0] analog_span,
  output logic switch_out,
  output logic switch_oe,
  output logic switch_state,
  output logic config_reject,
  output logic button_locked,
  output logic [15:0] active_port,
  output transport_e active_transport,
  output logic conn_probe_on
);
  initial
  begin
    if (NSIG < 1 || NSIG > 32 || LOCK_UNIT_CYCLES < 1)
    begin
      $error("Unsupported parameter values.");
    end
  end

  // Settings are checked against their legal ranges; illegal ones are dropped, except lock_minutes, which the lock timer uses as given,
  // and error_hold_count, which is taken even when illegal while error_hold_mode is not HOLD_COUNT.
  logic dec_ok, hold_ok, fpp_ok, lim_ok, hys_ok, scale_ok, port_ok, lock_ok;
  always_comb
  begin
    dec_ok = output_decimation_count >= 1 && output_decimation_count <= DECIM_W'(DECIM_MAX);
    hold_ok = error_hold_count >= 1 && error_hold_count <= HOLD_W'(HOLD_MAX);
    fpp_ok = frames_per_packet <= FPP_W'(FPP_MAX);
    lim_ok = limit_lower >= -LIMIT_MAX_UM && limit_lower <= LIMIT_MAX_UM
      && limit_upper >= -LIMIT_MAX_UM && limit_upper <= LIMIT_MAX_UM;
    hys_ok = switch_hysteresis >= 0 && switch_hysteresis <= (measuring_span <<< 1);
    scale_ok = scale_bound_1 != scale_bound_2 && scale_bound_1 >= -LIMIT_MAX_UM
      && scale_bound_1 <= LIMIT_MAX_UM && scale_bound_2 >= -LIMIT_MAX_UM
      && scale_bound_2 <= LIMIT_MAX_UM;
    port_ok = transport_port >= 16'(PORT_MIN);
    lock_ok = lock_minutes >= 6'h1 && lock_minutes <= 6'(LOCK_MIN_MAX);
    config_reject = !(dec_ok && hold_ok && fpp_ok && lim_ok && hys_ok && scale_ok
      && port_ok && lock_ok);
  end

  // Effective settings register only while legal; error_hold_count also while error_hold_mode is not HOLD_COUNT.
  logic [DECIM_W-1:0] dec_n_q, dec_n_d;
  logic [HOLD_W-1:0] hold_n_q, hold_n_d;
  hold_mode_e hmode_q, hmode_d;
  logic signed [31:0] lo_q, lo_d, hi_q, hi_d, hys_q, hys_d, sb1_q, sb1_d, sb2_q, sb2_d;
  logic [FPP_W-1:0] fpp_q, fpp_d;
  logic [15:0] port_q, port_d;
  // Decimation, hold and packing state.
  logic [DECIM_W-1:0] dec_cnt_q, dec_cnt_d;
  logic [HOLD_W-1:0] hold_cnt_q, hold_cnt_d;
  logic [NSIG*VAL_W-1:0] last_q, last_d, frame_q, frame_d;
  logic [NSIG-1:0] net_sel_q, net_sel_d, ser_sel_q, ser_sel_d;
  logic [$clog2(NSIG+1)-1:0] idx_q, idx_d;
  logic busy_q, busy_d, dec_keep_q, dec_keep_d;
  logic [FPP_W-1:0] pkt_cnt_q, pkt_cnt_d;
  logic [FPP_W-1:0] pkt_lim;
  logic net_in_valid, net_in_ready, ser_in_valid, ser_in_ready, net_in_last;
  logic [VAL_W-1:0] word;
  logic [NSIG*VAL_W-1:0] cond_vals;
  logic err_cycle, accept, cfg_change_dec, cfg_change_hold, step;
  logic dec_hit;

  always_comb
  begin
    hmode_d = hmode_q;
    hold_n_d = hold_n_q;
    dec_n_d = dec_n_q;
    lo_d = lo_q;
    hi_d = hi_q;
    hys_d = hys_q;
    sb1_d = sb1_q;
    sb2_d = sb2_q;
    fpp_d = fpp_q;
    port_d = port_q;
    if (dec_ok) dec_n_d = output_decimation_count;
    if (error_hold_mode != HOLD_COUNT || hold_ok)
    begin
      hmode_d = error_hold_mode;
      hold_n_d = error_hold_count;
    end
    if (lim_ok)
    begin
      lo_d = limit_lower;
      hi_d = limit_upper;
    end
    if (hys_ok) hys_d = switch_hysteresis;
    if (scale_ok)
    begin
      sb1_d = scale_bound_1;
      sb2_d = scale_bound_2;
    end
    if (fpp_ok) fpp_d = frames_per_packet;
    if (port_ok) port_d = transport_port;
    cfg_change_dec = dec_n_d != dec_n_q;
    cfg_change_hold = hmode_d != hmode_q || hold_n_d != hold_n_q;
    accept = meas_valid && !busy_q;
    err_cycle = meas_intensity_err || meas_range_err;
    // Hold logic decides what an errored cycle carries.
    last_d = last_q;
    hold_cnt_d = hold_cnt_q;
    cond_vals = meas_values;
    if (accept)
    begin
      if (!err_cycle)
      begin
        last_d = meas_values;
        hold_cnt_d = '0;
      end
      else
      begin
        cond_vals = {NSIG{error_value}};
        if (hmode_q == HOLD_INFINITE)
        begin
          cond_vals = last_q;
        end
        else if (hmode_q == HOLD_COUNT && hold_cnt_q < hold_n_q)
        begin
          cond_vals = last_q;
          hold_cnt_d = hold_cnt_q + HOLD_W'(1);
        end
      end
    end
    if (cfg_change_hold) hold_cnt_d = '0;
    // Decimation keeps the first of each group of n.
    dec_hit = dec_cnt_q == '0;
    dec_cnt_d = dec_cnt_q;
    if (accept)
    begin
      dec_cnt_d = (dec_cnt_q + DECIM_W'(1) >= dec_n_q) ? '0 : dec_cnt_q + DECIM_W'(1);
    end
    if (cfg_change_dec) dec_cnt_d = '0;
    // Serialiser walks the selected signals in order.
    frame_d = frame_q;
    net_sel_d = net_sel_q;
    ser_sel_d = ser_sel_q;
    idx_d = idx_q;
    busy_d = busy_q;
    dec_keep_d = dec_keep_q;
    if (accept)
    begin
      frame_d = cond_vals;
      net_sel_d = (!decimation_targets[TGT_NETWORK] || dec_hit) ? network_signal_selection : '0;
      ser_sel_d = (!decimation_targets[TGT_SERIAL] || dec_hit) ? serial_signal_selection : '0;
      dec_keep_d = !decimation_targets[TGT_ANALOG] || dec_hit;
      idx_d = '0;
      busy_d = 1'b1;
    end
    word = frame_q[idx_q[$clog2(NSIG)-1:0]*VAL_W +: VAL_W];
    net_in_valid = busy_q && net_sel_q[idx_q[$clog2(NSIG)-1:0]];
    ser_in_valid = busy_q && ser_sel_q[idx_q[$clog2(NSIG)-1:0]];
    step = busy_q && (!net_in_valid || net_in_ready) && (!ser_in_valid || ser_in_ready);
    net_in_last = 1'b0;
    pkt_lim = (fpp_q == '0) ? FPP_AUTO_COUNT : fpp_q;
    pkt_cnt_d = pkt_cnt_q;
    if (step)
    begin
      net_sel_d[idx_q[$clog2(NSIG)-1:0]] = 1'b0;
      ser_sel_d[idx_q[$clog2(NSIG)-1:0]] = 1'b0;
      if (net_in_valid && (net_sel_q >> idx_q) == 1)
      begin
        net_in_last = pkt_cnt_q + FPP_W'(1) >= pkt_lim;
        pkt_cnt_d = net_in_last ? '0 : pkt_cnt_q + FPP_W'(1);
      end
      if (idx_q == ($clog2(NSIG+1))'(NSIG - 1)) busy_d = 1'b0;
      else idx_d = idx_q + 1'b1;
    end
  end

  logic [VAL_W:0] net_out_word;
  skid_buffer #(.WIDTH(VAL_W + 1)) net_buf (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(net_in_valid && step),
    .in_ready(net_in_ready),
    .in_data({net_in_last, word}),
    .out_valid(net_valid),
    .out_ready(net_ready),
    .out_data(net_out_word)
  );
  assign net_data = net_out_word[VAL_W-1:0];
  assign net_last = net_out_word[VAL_W];

  skid_buffer #(.WIDTH(VAL_W)) ser_buf (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(ser_in_valid && step),
    .in_ready(ser_in_ready),
    .in_data(word),
    .out_valid(ser_valid),
    .out_ready(ser_ready),
    .out_data(ser_data)
  );

  // Switch output with hysteresis; limit and scaling use micrometre integers.
  logic sw_q, sw_d, an_v_q, an_v_d;
  logic signed [31:0] lsig, an_q, an_d, alo_q, alo_d, asp_q, asp_d;
  logic below, above, back_lo, back_hi;
  always_comb
  begin
    lsig = $signed(cond_vals[limit_source_signal*VAL_W +: VAL_W]);
    below = lsig < lo_q;
    above = lsig > hi_q;
    back_lo = lsig >= lo_q + hys_q;
    back_hi = lsig <= hi_q - hys_q;
    sw_d = sw_q;
    if (accept)
    begin
      case (error_output_source)
        SRC_INTENSITY: sw_d = meas_intensity_err;
        SRC_RANGE: sw_d = meas_range_err;
        SRC_EITHER: sw_d = err_cycle;
        SRC_LIMIT:
        begin
          if (!sw_q)
          begin
            sw_d = (limit_direction != DIR_UPPER && below)
              || (limit_direction != DIR_LOWER && above);
          end
          else
          begin
            sw_d = !((limit_direction == DIR_UPPER || back_lo)
              && (limit_direction == DIR_LOWER || back_hi));
          end
        end
        default: sw_d = 1'b0;
      endcase
    end
    an_d = an_q;
    an_v_d = 1'b0;
    if (analog_scaling_style == SCALE_TWO_POINT)
    begin
      alo_d = sb1_q;
      asp_d = sb2_q - sb1_q;
    end
    else if (thickness_mode)
    begin
      alo_d = '0;
      asp_d = measuring_span <<< 1;
    end
    else
    begin
      alo_d = -(measuring_span >>> 1);
      asp_d = measuring_span;
    end
    if (accept && dec_keep_d)
    begin
      an_d = lsig - alo_d;
      an_v_d = 1'b1;
    end
    case (switch_drive_style)
      DRIVE_HIGH_SIDE:
      begin
        switch_out = 1'b1;
        switch_oe = sw_q;
      end
      DRIVE_LOW_SIDE:
      begin
        switch_out = 1'b0;
        switch_oe = sw_q;
      end
      DRIVE_PUSH_PULL:
      begin
        switch_out = sw_q;
        switch_oe = 1'b1;
      end
      default:
      begin
        switch_out = !sw_q;
        switch_oe = 1'b1;
      end
    endcase
  end

  // Button lock timer and transport options.
  logic [$clog2(LOCK_UNIT_CYCLES*LOCK_MIN_MAX+1)-1:0] lock_cnt_q, lock_cnt_d;
  logic locked_q, locked_d, probe_q, probe_d;
  always_comb
  begin
    lock_cnt_d = lock_cnt_q;
    locked_d = locked_q;
    case (button_lock)
      LOCK_NONE: locked_d = 1'b0;
      LOCK_ACTIVE: locked_d = 1'b1;
      LOCK_AUTO:
      begin
        if (lock_cnt_q >= $bits(lock_cnt_q)'(LOCK_UNIT_CYCLES * lock_minutes)) locked_d = 1'b1;
        else lock_cnt_d = lock_cnt_q + 1'b1;
      end
      default: locked_d = 1'b0;
    endcase
    probe_d = conn_open ? probe_q : tcp_liveness_probe;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dec_n_q <= DECIM_W'(1);
      hold_n_q <= HOLD_W'(1);
      hmode_q <= HOLD_NONE;
      lo_q <= '0;
      hi_q <= '0;
      hys_q <= '0;
      sb1_q <= '0;
      sb2_q <= '0;
      fpp_q <= '0;
      port_q <= PORT_RESET;
      dec_cnt_q <= '0;
      hold_cnt_q <= '0;
      last_q <= '0;
      frame_q <= '0;
      net_sel_q <= '0;
      ser_sel_q <= '0;
      idx_q <= '0;
      busy_q <= 1'b0;
      dec_keep_q <= 1'b0;
      pkt_cnt_q <= '0;
      sw_q <= 1'b0;
      an_q <= '0;
      an_v_q <= 1'b0;
      alo_q <= '0;
      asp_q <= '0;
      lock_cnt_q <= '0;
      locked_q <= 1'b0;
      probe_q <= 1'b0;
    end
    else if (clk_en)
    begin
      dec_n_q <= dec_n_d;
      hold_n_q <= hold_n_d;
      hmode_q <= hmode_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      hys_q <= hys_d;
      sb1_q <= sb1_d;
      sb2_q <= sb2_d;
      fpp_q <= fpp_d;
      port_q <= port_d;
      dec_cnt_q <= dec_cnt_d;
      hold_cnt_q <= hold_cnt_d;
      last_q <= last_d;
      frame_q <= frame_d;
      net_sel_q <= net_sel_d;
      ser_sel_q <= ser_sel_d;
      idx_q <= idx_d;
      busy_q <= busy_d;
      dec_keep_q <= dec_keep_d;
      pkt_cnt_q <= pkt_cnt_d;
      sw_q <= sw_d;
      an_q <= an_d;
      an_v_q <= an_v_d;
      alo_q <= alo_d;
      asp_q <= asp_d;
      lock_cnt_q <= lock_cnt_d;
      locked_q <= locked_d;
      probe_q <= probe_d;
    end
  end

  assign analog_valid = an_v_q;
  assign analog_value = an_q;
  assign analog_lo = alo_q;
  assign analog_span = asp_q;
  assign switch_state = sw_q;
  assign button_locked = locked_q;
  assign active_port = port_q;
  assign active_transport = value_transport;
  assign conn_probe_on = probe_q;
endmodule // measured_value_output_conditioner
`default_nettype wire

// ### mvoc_sva.sv
// Port-level checker of the measured value output conditioner.
`timescale 1ns/1ps
`default_nettype none
module mvoc_sva
  import mvoc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic net_valid,
  input wire logic net_ready,
  input wire logic [VAL_W-1:0] net_data,
  input wire logic ser_valid,
  input wire logic ser_ready,
  input wire logic [VAL_W-1:0] ser_data,
  input wire logic switch_out,
  input wire logic switch_oe,
  input wire logic switch_state,
  input wire drive_style_e switch_drive_style,
  input wire logic config_reject,
  input wire logic [FPP_W-1:0] frames_per_packet,
  input wire logic [DECIM_W-1:0] output_decimation_count,
  input wire scale_style_e analog_scaling_style,
  input wire logic signed [31:0] scale_bound_1,
  input wire logic signed [31:0] scale_bound_2,
  input wire logic conn_open,
  input wire logic conn_probe_on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_push_pull_drive: assert property (switch_drive_style == DRIVE_PUSH_PULL |->
    switch_oe && switch_out == switch_state) else $error("push-pull pin wrong");
  a_inverted_drive: assert property (switch_drive_style == DRIVE_INV_PUSH_PULL |->
    switch_oe && switch_out != switch_state) else $error("inverted pin wrong");
  a_high_side_drive: assert property (switch_drive_style == DRIVE_HIGH_SIDE |->
    switch_oe == switch_state && (!switch_oe || switch_out)) else $error("high-side pin wrong");
  a_low_side_drive: assert property (switch_drive_style == DRIVE_LOW_SIDE |->
    switch_oe == switch_state && (!switch_oe || !switch_out)) else $error("low-side pin wrong");
  a_net_word_held: assert property (net_valid && !net_ready |=>
    net_valid && $stable(net_data)) else $error("network word dropped");
  a_ser_word_held: assert property (ser_valid && !ser_ready |=>
    ser_valid && $stable(ser_data)) else $error("serial word dropped");
  a_packet_limit_refused: assert property (frames_per_packet > FPP_MAX |->
    config_reject) else $error("frame count over limit taken");
  a_decim_range_refused: assert property ((output_decimation_count == 0 ||
    output_decimation_count > DECIM_MAX) |-> config_reject) else $error("bad count taken");
  a_equal_bounds_refused: assert property (analog_scaling_style == SCALE_TWO_POINT &&
    scale_bound_1 == scale_bound_2 |-> config_reject) else $error("equal bounds taken");
  a_probe_kept_open: assert property (conn_open && $past(conn_open) |->
    $stable(conn_probe_on)) else $error("probe changed on open connection");
endmodule // mvoc_sva
`default_nettype wire

// ### host_model.sv
// Host side model that takes network and serial words with random stalls.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic net_valid,
  output logic net_ready,
  input wire logic [31:0] net_data,
  input wire logic net_last,
  input wire logic ser_valid,
  output logic ser_ready,
  input wire logic [31:0] ser_data
);
  logic [31:0] net_q[$];
  logic last_q[$];
  logic [31:0] ser_q[$];
  initial
  begin
    net_ready = 1'b0;
    ser_ready = 1'b0;
  end
  // Ready changes just after the edge, so a word is taken only where both sides agree.
  always @(posedge core_clk)
  begin
    if (!rst && net_valid && net_ready)
    begin
      net_q.push_back(net_data);
      last_q.push_back(net_last);
    end
    if (!rst && ser_valid && ser_ready)
      ser_q.push_back(ser_data);
    #1;
    net_ready = !stall && ($urandom % 4 != 0);
    ser_ready = !stall && ($urandom % 3 != 0);
  end
endmodule // host_model
`default_nettype wire

// ### measured_value_output_conditioner_test.sv
// Self-checking bench of the measured value output conditioner.
`timescale 1ns/1ps
`default_nettype none
module measured_value_output_conditioner_test;
  import mvoc_pkg::*;
  localparam int NS = 8;
  logic core_clk, rst, clk_en, meas_valid, meas_intensity_err, meas_range_err, thickness_mode;
  logic tcp_liveness_probe, conn_open, stall, net_valid, net_ready, net_last, ser_valid;
  logic ser_ready, analog_valid, switch_out, switch_oe, switch_state, config_reject;
  logic button_locked, conn_probe_on;
  logic [NS*VAL_W-1:0] meas_values, v, g, ef;
  logic [VAL_W-1:0] error_value, net_data, ser_data;
  logic [2:0] limit_source_signal, decimation_targets;
  logic [DECIM_W-1:0] output_decimation_count;
  hold_mode_e error_hold_mode;
  logic [HOLD_W-1:0] error_hold_count;
  logic [FPP_W-1:0] frames_per_packet;
  logic [NS-1:0] network_signal_selection, serial_signal_selection;
  err_source_e error_output_source;
  limit_dir_e limit_direction;
  logic signed [31:0] limit_lower, limit_upper, switch_hysteresis, measuring_span;
  logic signed [31:0] scale_bound_1, scale_bound_2, analog_value, analog_lo, analog_span;
  drive_style_e switch_drive_style;
  scale_style_e analog_scaling_style;
  lock_mode_e button_lock;
  logic [5:0] lock_minutes;
  transport_e value_transport, active_transport;
  logic [15:0] transport_port, active_port;
  int err_total, n_compared;
  int lim_v[9] = '{-1100, -950, -850, 1100, 950, 850, 1100, -1100, 0};
  measured_value_output_conditioner #(.NSIG(NS), .LOCK_UNIT_CYCLES(10)) dut_u (
    .core_clk, .rst, .clk_en, .meas_valid, .meas_values, .meas_intensity_err, .meas_range_err,
    .error_value, .limit_source_signal, .thickness_mode, .output_decimation_count,
    .decimation_targets, .error_hold_mode, .error_hold_count, .frames_per_packet,
    .network_signal_selection, .serial_signal_selection, .error_output_source,
    .limit_direction, .limit_lower, .limit_upper, .switch_hysteresis, .measuring_span,
    .switch_drive_style, .analog_scaling_style, .scale_bound_1, .scale_bound_2, .button_lock,
    .lock_minutes, .value_transport, .transport_port, .tcp_liveness_probe, .conn_open,
    .net_valid, .net_ready, .net_data, .net_last, .ser_valid, .ser_ready, .ser_data,
    .analog_valid, .analog_value, .analog_lo, .analog_span, .switch_out, .switch_oe,
    .switch_state, .config_reject, .button_locked, .active_port, .active_transport,
    .conn_probe_on);
  host_model host_u (.*);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [NS*VAL_W-1:0] rnd();
    logic [NS*VAL_W-1:0] r;
    for (int k = 0; k < NS; k++)
      r[k*VAL_W+:VAL_W] = $urandom;
    return r;
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // A stalled host keeps valid up, so the wait is bounded.
  task automatic measure(logic [NS*VAL_W-1:0] x, logic ie, logic re);
    meas_values = x;
    meas_intensity_err = ie;
    meas_range_err = re;
    meas_valid = 1'b1;
    @(posedge core_clk);
    #1 meas_valid = 1'b0;
    repeat (NS + 4) @(posedge core_clk);
    #1;
    for (int i = 0; i < 300 && (net_valid || ser_valid); i++)
      settle();
  endtask
  task automatic expect_frame(logic [NS*VAL_W-1:0] x, logic to_net, logic to_ser);
    logic [31:0] w;
    for (int k = 0; k < NS; k++)
    begin
      if (to_net && network_signal_selection[k])
      begin
        w = host_u.net_q.size() > 0 ? host_u.net_q.pop_front() : 32'hxxxx_xxxx;
        check("net word", w, x[k*VAL_W+:VAL_W]);
      end
      if (to_ser && serial_signal_selection[k])
      begin
        w = host_u.ser_q.size() > 0 ? host_u.ser_q.pop_front() : 32'hxxxx_xxxx;
        check("ser word", w, x[k*VAL_W+:VAL_W]);
      end
    end
  endtask
  task automatic results();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #300000;
    err_total++;
    results();
  end
  initial
  begin
    void'($urandom(36928));
    {rst, clk_en, meas_valid, meas_intensity_err, meas_range_err, thickness_mode} = 6'b11_0000;
    {tcp_liveness_probe, conn_open, stall} = 3'b000;
    meas_values = '0;
    error_value = $urandom;
    ef = {NS{error_value}};
    limit_source_signal = 3'h2;
    decimation_targets = 3'b000;
    output_decimation_count = 22'h00_0001;
    error_hold_mode = HOLD_NONE;
    error_hold_count = 11'h001;
    frames_per_packet = 9'h002;
    network_signal_selection = 8'h01;
    serial_signal_selection = 8'h80;
    error_output_source = SRC_INTENSITY;
    limit_direction = DIR_UPPER;
    limit_lower = -32'sd1000;
    limit_upper = 32'sd1000;
    switch_hysteresis = 32'sd100;
    measuring_span = 32'sh0000_2710;
    switch_drive_style = DRIVE_PUSH_PULL;
    analog_scaling_style = SCALE_STANDARD;
    scale_bound_1 = -32'sd5000;
    scale_bound_2 = 32'sd5000;
    button_lock = LOCK_ACTIVE;
    lock_minutes = 6'h02;
    value_transport = XPORT_SERVER_TCP;
    transport_port = 16'h0400;
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    check("reset port", active_port, 16'h0400);
    for (int i = 0; i < 4; i++)
    begin
      v = rnd();
      measure(v, 1'b0, 1'b0);
      expect_frame(v, 1'b1, 1'b1);
      check("analog", analog_value, v[2*VAL_W+:VAL_W] + 32'sd5000);
    end
    for (int i = 0; i < 4; i++)
      check("packet end", host_u.last_q.pop_front(), i % 2);
    check("locked", button_locked, 1);
    for (int i = 0; i < 4; i++)
    begin
      network_signal_selection = NS'($urandom) | 8'h01;
      serial_signal_selection = NS'($urandom) | 8'h10;
      stall = (i == 3);
      v = rnd();
      measure(v, 1'b0, 1'b0);
      stall = 1'b0;
      measure(rnd(), 1'b0, 1'b0);
      expect_frame(v, 1'b1, 1'b1);
      host_u.net_q.delete();
      host_u.ser_q.delete();
    end
    for (int s = 0; s < 3; s++)
      for (int f = 0; f < 4; f++)
      begin
        error_output_source = err_source_e'(s);
        switch_drive_style = drive_style_e'(f);
        v = rnd();
        measure(v, f[0], f[1]);
        expect_frame(f != 0 ? ef : v, 1'b1, 1'b1);
        check("switch state", switch_state, s == 2 ? f != 0 : f[s]);
      end
    error_output_source = SRC_LIMIT;
    for (int i = 0; i < 9; i++)
    begin
      limit_direction = limit_dir_e'(i / 3);
      v = rnd();
      v[2*VAL_W+:VAL_W] = lim_v[i];
      measure(v, 1'b0, 1'b0);
      expect_frame(v, 1'b1, 1'b1);
      check("limit state", switch_state, i % 3 != 2);
    end
    error_hold_mode = HOLD_COUNT;
    error_hold_count = 11'h002;
    g = rnd();
    measure(g, 1'b0, 1'b0);
    expect_frame(g, 1'b1, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 3)
      begin
        error_hold_mode = HOLD_INFINITE;
        settle();
      end
      measure(rnd(), 1'b1, 1'b0);
      expect_frame(i == 2 ? ef : g, 1'b1, 1'b1);
    end
    error_hold_mode = HOLD_NONE;
    decimation_targets = 3'b001;
    output_decimation_count = 22'h00_0003;
    settle();
    for (int i = 0; i < 6; i++)
    begin
      v = rnd();
      measure(v, 1'b0, 1'b0);
      expect_frame(v, 1'b1, i % 3 == 0);
    end
    check("ser extra", host_u.ser_q.size(), 0);
    frames_per_packet = 9'h15F;
    #1 check("fpp refused", config_reject, 1);
    frames_per_packet = 9'h15E;
    output_decimation_count = 22'h00_0000;
    #1 check("count refused", config_reject, 1);
    output_decimation_count = 22'h2D_C6C0;
    limit_upper = LIMIT_MAX_UM + 32'sh0000_0001;
    #1 check("limit refused", config_reject, 1);
    limit_upper = LIMIT_MAX_UM;
    analog_scaling_style = SCALE_TWO_POINT;
    scale_bound_2 = scale_bound_1;
    #1 check("bounds refused", config_reject, 1);
    scale_bound_2 = 32'sh0000_1388;
    #1 check("all legal", config_reject, 0);
    value_transport = XPORT_CLIENT_UDP;
    transport_port = 16'h03FF;
    settle();
    check("port kept", active_port, 16'h0400);
    transport_port = 16'h1388;
    settle();
    check("port taken", active_port, 16'h1388);
    check("transport", active_transport, XPORT_CLIENT_UDP);
    conn_open = 1'b1;
    settle();
    tcp_liveness_probe = 1'b1;
    settle();
    check("probe kept", conn_probe_on, 0);
    conn_open = 1'b0;
    settle();
    check("probe new", conn_probe_on, 1);
    button_lock = LOCK_AUTO;
    rst = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (15) @(posedge core_clk);
    #1 check("lock early", button_locked, 0);
    repeat (10) @(posedge core_clk);
    #1 check("lock late", button_locked, 1);
    results();
  end
endmodule // measured_value_output_conditioner_test
bind measured_value_output_conditioner mvoc_sva chk_u (.*);
`default_nettype wire
